/* hw/sar_adc_control.sv */
// converter control: conversion sequencer, apb registers and serial output pins
//
// Summary of operation
// - daisy-select low: shared pin enables or disables the serial output.
// - daisy-select high: shared pin is serial data input from upstream converter.
// - every convert-start rising edge begins a new conversion while control bit 0 is set.
// - after a conversion, stay powered down while convert-start stays high.
// - convert-start low again powers the converter back up.
// - busy rises when a conversion begins, falls when it completes.
// - enabled output shifts result or chain data, msb first, per rising sck.
// - result is two's complement over twice the reference span.
// - capacitor dac steps a binary search, deciding one bit per step.
// - finished 16-bit result is loaded into the serial output path.
// - conversion timed by internal clock; host supplies no conversion clock.
// - result ready right after its conversion, no pipeline latency.
`timescale 1ns/1ps
module sar_adc_control (
    // core clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // converter pins
    input  wire logic        CONVERT_START,
    input  wire logic        CHAIN_SELECT,
    input  wire logic        OUT_ENABLE_OR_CHAIN_IN,
    output logic             BUSY,
    output logic             POWER_DOWN,
    // serial link
    input  wire logic        SCK,
    output logic             SDO,
    output logic             SDO_OE_N,
    // analog core: latched comparator strobed by CORE_CLK, dac trial code
    input  wire logic        COMP_ABOVE,
    output logic      [15:0] CAP_WEIGHT_DAC
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic cstart_s1_q, cstart_s2_q, cstart_s3_q;
    logic chain_s1_q, chain_s2_q;
    logic read_enable_low_s1_q, read_enable_low_s2_q;

    always_ff @(posedge CORE_CLK) begin
        cstart_s1_q          <= CONVERT_START;
        cstart_s2_q          <= cstart_s1_q;
        cstart_s3_q          <= cstart_s2_q;
        chain_s1_q           <= CHAIN_SELECT;
        chain_s2_q           <= chain_s1_q;
        read_enable_low_s1_q <= OUT_ENABLE_OR_CHAIN_IN;
        read_enable_low_s2_q <= read_enable_low_s1_q;
    end

    logic cstart_rise;
    assign cstart_rise = cstart_s2_q & ~cstart_s3_q;

    function automatic logic [15:0] bit_mask(input logic [3:0] idx);
        bit_mask = 16'(16'h0001 << idx);
    endfunction : bit_mask

    ////////////////////////////////////////////////////////////////////////////
    // conversion sequencer
    sar_pkg::conv_state_t state_q, state_d;
    logic [9:0]  step_q, step_d;
    logic [3:0]  idx_q, idx_d;
    logic [15:0] dac_q, dac_d;
    logic [15:0] result_q, result_d;
    logic        tag_q, tag_d;
    logic [15:0] count_q, count_d;
    logic        busy_q, busy_d;
    logic        pdn_q, pdn_d;
    logic        ctrl_en_q, ctrl_en_d;
    logic        start;
    logic        step_end;
    logic        done;
    logic [15:0] trial;
    logic        count_clr;

    assign start    = cstart_rise & ctrl_en_q;
    assign step_end = (state_q == sar_pkg::ST_CONV) && (step_q == sar_pkg::BIT_CYC_M1);
    assign done     = step_end && (idx_q == 4'h0) && !start;
    // keep the trial bit only when the sample sits above the dac level
    assign trial    = COMP_ABOVE ? dac_q : (dac_q & ~bit_mask(idx_q));

    always_comb begin
        state_d  = state_q;
        step_d   = step_q;
        idx_d    = idx_q;
        dac_d    = dac_q;
        result_d = result_q;
        tag_d    = tag_q;
        count_d  = count_clr ? sar_pkg::COUNT_RST : count_q;
        if (start) begin
            // a restart mid-conversion discards the partial code
            state_d = sar_pkg::ST_CONV;
            step_d  = 10'h000;
            idx_d   = sar_pkg::MSB_IDX;
            dac_d   = sar_pkg::DAC_START;
        end else begin
            unique case (state_q)
                sar_pkg::ST_IDLE: begin
                    dac_d = 16'h0000;
                end
                sar_pkg::ST_CONV: begin
                    if (step_end) begin
                        step_d = 10'h000;
                        if (idx_q == 4'h0) begin
                            result_d = trial ^ sar_pkg::MSB_FLIP;
                            tag_d    = ~tag_q;
                            state_d  = sar_pkg::ST_PDOWN;
                            count_d  = 16'(count_d + 16'h0001);
                            dac_d    = trial;
                        end else begin
                            idx_d = 4'(idx_q - 4'h1);
                            dac_d = trial | bit_mask(4'(idx_q - 4'h1));
                        end
                    end else begin
                        step_d = 10'(step_q + 10'h001);
                    end
                end
                sar_pkg::ST_PDOWN: begin
                    if (!cstart_s2_q) begin
                        state_d = sar_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_d = sar_pkg::ST_IDLE;
                end
            endcase
        end
        busy_d = (state_d == sar_pkg::ST_CONV);
        pdn_d  = (state_d == sar_pkg::ST_PDOWN);
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            state_q  <= sar_pkg::ST_IDLE;
            step_q   <= 10'h000;
            idx_q    <= sar_pkg::MSB_IDX;
            dac_q    <= 16'h0000;
            result_q <= sar_pkg::RESULT_RST;
            tag_q    <= 1'b0;
            count_q  <= sar_pkg::COUNT_RST;
            busy_q   <= 1'b0;
            pdn_q    <= 1'b0;
        end else begin
            state_q  <= state_d;
            step_q   <= step_d;
            idx_q    <= idx_d;
            dac_q    <= dac_d;
            result_q <= result_d;
            tag_q    <= tag_d;
            count_q  <= count_d;
            busy_q   <= busy_d;
            pdn_q    <= pdn_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output enable: chain mode always drives, normal mode follows the pin
    logic oe_n_q, oe_n_d;

    always_comb begin
        oe_n_d = chain_s2_q ? 1'b0 : read_enable_low_s2_q;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= oe_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait, data registered in setup, answer in access phase
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        setup;
    logic        wr_fire;

    function automatic logic reg_hit(input logic [11:0] addr);
        reg_hit = (addr == sar_pkg::OFS_CTRL)   || (addr == sar_pkg::OFS_STATUS) ||
                  (addr == sar_pkg::OFS_RESULT) || (addr == sar_pkg::OFS_COUNT);
    endfunction : reg_hit

    assign setup     = PSEL & ~PENABLE;
    assign wr_fire   = PSEL & PENABLE & pready_q & PWRITE & ~pslverr_q;
    assign count_clr = wr_fire && (PADDR == sar_pkg::OFS_COUNT);

    always_comb begin
        pready_d  = setup;
        pslverr_d = setup ? ~reg_hit(PADDR) : 1'b0;
        prdata_d  = prdata_q;
        ctrl_en_d = ctrl_en_q;
        if (setup) begin
            prdata_d = 32'h0000_0000;
            if (!PWRITE) begin
                unique case (PADDR)
                    sar_pkg::OFS_CTRL: begin
                        prdata_d[sar_pkg::CTRL_EN_BIT] = ctrl_en_q;
                    end
                    sar_pkg::OFS_STATUS: begin
                        prdata_d[sar_pkg::ST_BUSY_BIT]  = busy_q;
                        prdata_d[sar_pkg::ST_PDN_BIT]   = pdn_q;
                        prdata_d[sar_pkg::ST_CHAIN_BIT] = chain_s2_q;
                        prdata_d[sar_pkg::ST_OEN_BIT]   = oe_n_q;
                    end
                    sar_pkg::OFS_RESULT: begin
                        prdata_d[15:0] = result_q;
                    end
                    sar_pkg::OFS_COUNT: begin
                        prdata_d[15:0] = count_q;
                    end
                    default: begin
                        prdata_d = 32'h0000_0000;
                    end
                endcase
            end
        end
        if (wr_fire && (PADDR == sar_pkg::OFS_CTRL)) begin
            ctrl_en_d = PWDATA[sar_pkg::CTRL_EN_BIT];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            ctrl_en_q <= sar_pkg::CTRL_EN_RST;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            ctrl_en_q <= ctrl_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial clock side
    sar_serial_port u_port (
        .sck         (SCK),
        .core_rstn   (RSTN),
        .result_word (result_q),
        .result_tag  (tag_q),
        .chain_mode  (chain_s2_q),
        .chain_in    (OUT_ENABLE_OR_CHAIN_IN),
        .sdo         (SDO)
    );

    assign PRDATA         = prdata_q;
    assign PREADY         = pready_q;
    assign PSLVERR        = pslverr_q;
    assign BUSY           = busy_q;
    assign POWER_DOWN     = pdn_q;
    assign SDO_OE_N       = oe_n_q;
    assign CAP_WEIGHT_DAC = dac_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    int          conv_len_q;
    localparam int CONV_LEN = sar_pkg::CONV_CYC;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN || start) begin
            conv_len_q <= 0;
        end else if (busy_q) begin
            conv_len_q <= conv_len_q + 1;
        end
    end

    a_start_busy: assert property (start |=> BUSY)
        else $error("busy not raised after convert-start edge");
    a_conv_length: assert property ($fell(BUSY) |-> conv_len_q == CONV_LEN)
        else $error("conversion length wrong");
    a_busy_done: assert property ($fell(BUSY) && !$past(start) |-> POWER_DOWN)
        else $error("busy fell without entering power-down");
    a_pdown_hold: assert property (POWER_DOWN && cstart_s2_q && !start |=> POWER_DOWN)
        else $error("power-down left while convert-start high");
    a_power_up: assert property (POWER_DOWN && !cstart_s2_q && !start |=> !POWER_DOWN)
        else $error("no power-up after convert-start low");
    a_result_load: assert property ($fell(BUSY) && !$past(start) |-> tag_q != $past(tag_q))
        else $error("result not handed to serial path");
    a_twos_comp: assert property (done |=> result_q[15:1] == ($past(dac_q[15:1]) ^ 15'h4000))
        else $error("result not two's complement of dac code");
    a_sar_step: assert property (step_end && idx_q != 4'h0 && !start |=>
        (CAP_WEIGHT_DAC & bit_mask(idx_q)) != 16'h0000 && idx_q == $past(idx_q) - 4'h1)
        else $error("dac trial bit not set at next position");
    a_oe_normal: assert property (!chain_s2_q |=> SDO_OE_N == $past(read_enable_low_s2_q))
        else $error("output enable does not follow pin");
    a_oe_chain: assert property (chain_s2_q |=> !SDO_OE_N)
        else $error("chain mode output not driven");
    a_apb_ready: assert property (setup |=> PREADY ##1 !PREADY || setup)
        else $error("apb answer not in access phase");

    c_conv_done: cover property (start ##1 BUSY [*8] ##[1:600] $fell(BUSY));
    c_power_up: cover property (POWER_DOWN ##[1:1000] !POWER_DOWN);
    c_chain: cover property (chain_s2_q && $fell(BUSY));
    c_ctrl_write: cover property (wr_fire && PADDR == sar_pkg::OFS_CTRL);

endmodule : sar_adc_control

/* hw/sar_pkg.sv */
// constants, register map and state codes of the converter control block
package sar_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // converter geometry and timing
    localparam int          DATA_W        = 16;
    localparam int          CLK_MHZ       = 250;
    localparam int          T_CONV_MIN_NS = 2000;
    localparam int          T_CONV_MAX_NS = 3000;
    // one bit decision per step; least conversion time rounds up to whole cycles
    localparam int          BIT_CYC       = (T_CONV_MIN_NS * CLK_MHZ + 1000 * DATA_W - 1)
                                            / (1000 * DATA_W);
    localparam int          CONV_CYC      = BIT_CYC * DATA_W;
    localparam logic [9:0]  BIT_CYC_M1    = 10'(BIT_CYC - 1);
    localparam logic [3:0]  MSB_IDX       = 4'hF;
    localparam logic [15:0] MSB_FLIP      = 16'h8000;
    localparam logic [15:0] DAC_START     = 16'h8000;
    localparam logic [4:0]  CHAIN_AFTER   = 5'h10;

    ////////////////////////////////////////////////////////////////////////////
    // apb register map (byte addresses)
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_STATUS    = 12'h004;
    localparam logic [11:0] OFS_RESULT    = 12'h008;
    localparam logic [11:0] OFS_COUNT     = 12'h00C;

    // control register: bit 0 lets convert-start edges begin conversions
    localparam int          CTRL_EN_BIT   = 0;
    localparam logic        CTRL_EN_RST   = 1'b1;
    // status register fields
    localparam int          ST_BUSY_BIT   = 0;
    localparam int          ST_PDN_BIT    = 1;
    localparam int          ST_CHAIN_BIT  = 2;
    localparam int          ST_OEN_BIT    = 3;
    localparam logic [15:0] COUNT_RST     = 16'h0000;
    localparam logic [15:0] RESULT_RST    = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // conversion sequencer, gray along idle -> convert -> power-down; power-down -> idle flips both bits
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CONV  = 2'b01,
        ST_PDOWN = 2'b11
    } conv_state_t;

endpackage : sar_pkg

/* hw/sar_serial_port.sv */
// serial-clock side of the converter: result readout and chain pass-through
`timescale 1ns/1ps
module sar_serial_port (
    // serial clock domain
    input  wire logic        sck,
    input  wire logic        core_rstn,
    // result word from the core; stable whenever result_tag is steady
    input  wire logic [15:0] result_word,
    input  wire logic        result_tag,
    input  wire logic        chain_mode,
    // chain data input and serial output
    input  wire logic        chain_in,
    output logic             sdo
);

    logic       rst_s1_q, rst_s2_q;
    logic       tag_s1_q, tag_s2_q, tag_seen_q, tag_seen_d;
    logic       mode_s1_q, mode_s2_q;
    logic [4:0] cnt_q, cnt_d;
    logic       sdo_q, sdo_d;
    logic       new_word;

    ////////////////////////////////////////////////////////////////////////////
    // crossings: reset, tag toggle and mode level each pass two flip-flops
    always_ff @(posedge sck) begin
        rst_s1_q  <= core_rstn;
        rst_s2_q  <= rst_s1_q;
        tag_s1_q  <= result_tag;
        tag_s2_q  <= tag_s1_q;
        mode_s1_q <= chain_mode;
        mode_s2_q <= mode_s1_q;
    end

    assign new_word = tag_s2_q ^ tag_seen_q;

    ////////////////////////////////////////////////////////////////////////////
    // shifter: word bits msb first, then chain data one edge later in chain mode, zeros in normal mode
    always_comb begin
        tag_seen_d = tag_s2_q;
        cnt_d      = cnt_q;
        sdo_d      = sdo_q;
        if (new_word) begin
            sdo_d = result_word[sar_pkg::MSB_IDX];
            cnt_d = 5'h01;
        end else if (cnt_q < sar_pkg::CHAIN_AFTER) begin
            sdo_d = result_word[4'(sar_pkg::MSB_IDX - cnt_q[3:0])];
            cnt_d = 5'(cnt_q + 5'h01);
        end else begin
            sdo_d = mode_s2_q & chain_in;
        end
    end

    always_ff @(posedge sck) begin
        if (!rst_s2_q) begin
            tag_seen_q <= 1'b0;
            cnt_q      <= sar_pkg::CHAIN_AFTER;
            sdo_q      <= 1'b0;
        end else begin
            tag_seen_q <= tag_seen_d;
            cnt_q      <= cnt_d;
            sdo_q      <= sdo_d;
        end
    end

    assign sdo = sdo_q;

    ////////////////////////////////////////////////////////////////////////////
    a_msb_first: assert property (@(posedge sck) disable iff (!rst_s2_q)
        new_word |=> sdo_q == $past(result_word[15]))
        else $error("msb not presented first after new result");
    a_chain_pass: assert property (@(posedge sck) disable iff (!rst_s2_q)
        (!new_word && cnt_q == sar_pkg::CHAIN_AFTER && mode_s2_q) |=> sdo_q == $past(chain_in))
        else $error("chain data not passed one edge later");

endmodule : sar_serial_port

/* test/serial_host.sv */
// far-side model: host serial clock, sdo capture and upstream chain data
`timescale 1ns/1ps
module serial_host (
    // serial link
    output logic      sck,
    output logic      chain_in,
    input  wire logic sdo
);
    initial begin
        sck = 1'b0;
        chain_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sck runs only inside a frame; phase kept apart from the core clock
    task automatic frame(input int n, input logic [15:0] up, output logic [31:0] got);
        int k;
        got = 32'h0000_0000;
        #3.3;
        for (k = 0; k < n; k++) begin
            sck = 1'b1;
            #2;
            // upstream msb set after our lsb edge, sampled on the next one; filler toggles
            if (k >= 17 && k < 33) chain_in = up[32 - k];
            else chain_in = ~chain_in;
            #5.5;
            sck = 1'b0;
            if (k >= 2) got = {got[30:0], sdo};
            #7.5;
        end
    endtask : frame
endmodule : serial_host

/* test/sar_adc_conversion_serial_readout_tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_conversion_serial_readout_tb;
    logic        clk;
    logic        rstn;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cs;
    logic        chain_sel;
    logic        rd_en_n;
    logic        busy;
    logic        pdn;
    logic        sck;
    logic        chain_in;
    logic        sdo;
    logic        sdo_oe_n;
    logic        comp;
    logic [15:0] dac;
    logic [15:0] smp;
    logic [31:0] rd;
    logic        er;
    logic [31:0] w;
    int          err_count;
    int          total_checks;
    int          n_conv;
    int          cyc;
    int          hits;
    integer      seed;
    wire         pin = chain_sel ? chain_in : rd_en_n;

    sar_adc_control dut (
        .CORE_CLK              (clk),
        .RSTN                  (rstn),
        .PSEL                  (psel),
        .PENABLE               (pen),
        .PWRITE                (pwr),
        .PADDR                 (paddr),
        .PWDATA                (pwdata),
        .PRDATA                (prdata),
        .PREADY                (pready),
        .PSLVERR               (pslverr),
        .CONVERT_START         (cs),
        .CHAIN_SELECT          (chain_sel),
        .OUT_ENABLE_OR_CHAIN_IN(pin),
        .BUSY                  (busy),
        .POWER_DOWN            (pdn),
        .SCK                   (sck),
        .SDO                   (sdo),
        .SDO_OE_N              (sdo_oe_n),
        .COMP_ABOVE            (comp),
        .CAP_WEIGHT_DAC        (dac)
    );

    serial_host host (
        .sck     (sck),
        .chain_in(chain_in),
        .sdo     (sdo)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // comparator: sample at or above the trial level
    always @(posedge clk) comp <= (smp >= dac);

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            err_count++;
            summarize();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic wt(input logic v, input int mx);
        cyc = 0;
        while (busy !== v) begin
            @(posedge clk);
            cyc++;
            if (cyc > mx) begin
                err_count++;
                summarize();
            end
        end
    endtask : wt

    // one conversion, register readback, serial frame and power cycle
    task automatic conv(input logic [15:0] s, input logic [15:0] up);
        int c;
        int b;
        logic [15:0] e;
        c = 0;
        for (b = 15; b >= 0; b--) if (int'(s) >= (c | (1 << b))) c = c | (1 << b);
        e = 16'(c - 32768);
        smp <= s;
        @(posedge clk);
        cs <= 1'b1;
        wt(1'b1, 20);
        chk("dac_first", 32'h0000_8000, {16'h0000, dac});
        wt(1'b0, 600);
        chk("busy_cycles", 32'(sar_pkg::CONV_CYC), 32'(cyc));
        @(posedge clk);
        chk("pdown", 32'h0000_0001, 32'(pdn));
        apb(1'b0, sar_pkg::OFS_RESULT, 32'h0000_0000);
        chk("result", {16'h0000, e}, rd);
        n_conv++;
        apb(1'b0, sar_pkg::OFS_COUNT, 32'h0000_0000);
        chk("count", 32'(n_conv), rd);
        apb(1'b0, sar_pkg::OFS_STATUS, 32'h0000_0000);
        chk("status", {29'h0, chain_sel, 2'b10}, {29'h0, rd[2:0]});
        host.frame(34, up, w);
        chk("serial", chain_sel ? {e, up} : {e, 16'h0000}, w);
        if (!chain_sel) chk("oe_n", 32'h0000_0000, 32'(sdo_oe_n));
        @(posedge clk);
        cs <= 1'b0;
        repeat (6) @(posedge clk);
        chk("pup", 32'h0000_0000, 32'(pdn));
        chk("dac_idle", 32'h0000_0000, {16'h0000, dac});
        // low time and cycle spacing kept well above the minimum
        repeat (600) @(posedge clk);
    endtask : conv

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h4a30;
        err_count = 0;
        total_checks = 0;
        n_conv = 0;
        rstn = 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        cs = 1'b0;
        chain_sel = 1'b0;
        rd_en_n = 1'b1;
        smp = 16'h0000;
        // the serial side resyncs reset, so it needs a few sck edges
        host.frame(3, 16'h0000, w);
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, sar_pkg::OFS_CTRL, 32'h0000_0000);
        chk("ctrl_rst", 32'h0000_0001, rd);
        apb(1'b0, sar_pkg::OFS_STATUS, 32'h0000_0000);
        chk("status_rst", 32'h0000_0008, rd);
        apb(1'b0, sar_pkg::OFS_RESULT, 32'h0000_0000);
        chk("result_rst", 32'h0000_0000, rd);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk("slverr_rd", 32'h0000_0001, 32'(er));
        chk("unmapped", 32'h0000_0000, rd);
        apb(1'b1, 12'h010, 32'h1234_5678);
        chk("slverr_wr", 32'h0000_0001, 32'(er));
        $display("test reset done");
        rd_en_n <= 1'b0;
        conv(16'h0000, 16'h0000);
        conv(16'hFFFF, 16'h0000);
        conv(16'($random(seed)), 16'h0000);
        @(posedge clk);
        rd_en_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("oe_release", 32'h0000_0001, 32'(sdo_oe_n));
        $display("test normal done");
        chain_sel <= 1'b1;
        repeat (4) @(posedge clk);
        conv(16'($random(seed)), 16'($random(seed)));
        $display("test chain done");
        chain_sel <= 1'b0;
        apb(1'b1, sar_pkg::OFS_CTRL, 32'h0000_0000);
        @(posedge clk);
        cs <= 1'b1;
        hits = 0;
        repeat (600) begin
            @(posedge clk);
            if (busy !== 1'b0) hits++;
        end
        chk("busy_off", 32'h0000_0000, 32'(hits));
        cs <= 1'b0;
        repeat (500) @(posedge clk);
        apb(1'b1, sar_pkg::OFS_CTRL, 32'h0000_0001);
        apb(1'b1, sar_pkg::OFS_COUNT, 32'h0000_FFFF);
        apb(1'b0, sar_pkg::OFS_COUNT, 32'h0000_0000);
        chk("count_clr", 32'h0000_0000, rd);
        n_conv = 0;
        rd_en_n <= 1'b0;
        conv(16'h8000, 16'h0000);
        $display("test disable done");
        summarize();
    end
endmodule : sar_adc_conversion_serial_readout_tb
